// ===== shared/asr_pkg.sv
// Constants and types shared by the serial receiver design
// Behaviour
// R1 - Falling edge on line starts a character
// R2 - Start not low at half bit: abandon silently
// R3 - Each bit taken at centre, majority voted
// R4 - Low stop bit marks framing error
// R5 - Finished character enters FIFO, pending raised
// R6 - Data read returns oldest, advances FIFO
// R7 - Pending follows FIFO while enabled, read-only
// R8 - Irq needs receive, peripheral, global enables
// R9 - Framing error bit follows oldest character
// R10 - Framing error read-only, advances with reads
// R11 - Port disable clears framing error; receive-disable keeps
// R12 - Framing error raises no irq, reception continues
// R13 - Third character into full FIFO sets overrun
// R14 - Overrun blocks new characters; receive disable clears it
// R15 - Nine-bit mode: ninth bit shown in status
// R16 - Software reads ninth bit before data
// R17 - Address mode keeps only ninth-bit-set characters
// R18 - Software drops address mode after own address
// R19 - Software configures everything before receive enable
// R20 - Active only with receive, async, port enabled
// R21 - Recovery at sixteen ticks per bit
// R22 - Port disable resets port, releases pins
// R23 - Majority of three samples at bit centre
// R24 - Receive disable aborts character, FIFO kept
package asr_pkg;
    // ***************
    // Register offsets
    // ***************
    localparam logic [7:0] OFS_RCV_STATUS = 8'h00;
    localparam logic [7:0] OFS_RCV_DATA = 8'h04;
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
    localparam logic [7:0] OFS_DIV_LOW = 8'h0c;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h10;
    localparam logic [7:0] OFS_TX_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h20;
    // ***************
    // Field positions
    // ***************
    localparam int BIT_PORT_EN = 7;
    localparam int BIT_NINE = 6;
    localparam int BIT_SINGLE = 5;
    localparam int BIT_CONT_EN = 4;
    localparam int BIT_ADDR_EN = 3;
    localparam int BIT_FRAME_ERROR_FLAG = 2;
    localparam int BIT_OVERRUN_FLAG = 1;
    localparam int BIT_RECEIVED_NINTH_BIT = 0;
    localparam int BIT_SYNC = 4;
    localparam int BIT_HIGH_RATE = 2;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_IDLE = 6;
    localparam int BIT_WIDE_DIV = 3;
    localparam int BIT_RX_IRQ = 5;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_EN = 6;
    // ***************
    // Write masks and reset values
    // ***************
    localparam logic [7:0] MASK_RCV_STATUS = 8'hf8;
    localparam logic [7:0] MASK_BAUD_CTRL = 8'h1b;
    localparam logic [7:0] MASK_TX_STATUS = 8'hfd;
    localparam logic [7:0] MASK_IRQ_CTRL = 8'hc0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ***************
    // Oversampling
    // ***************
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] PH_LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] PH_SAMPLE_A = 4'h7;
    localparam logic [3:0] PH_SAMPLE_B = 4'h8;
    localparam logic [3:0] PH_DECIDE = 4'h9;
    localparam int LOW_RATE_SHIFT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA = 2'b10,
        ASR_STOP = 2'b11
    } asr_state_e;
endpackage

// ===== shared/asr_rx_if.sv
// Link between register side and bit recovery engine
`timescale 1ns/1ps
interface asr_rx_if;
    logic tick;
    logic line;
    logic enable;
    logic nine;
    logic char_valid;
    logic [8:0] char_data;
    logic char_frame_error_flag;
    logic idle;
    modport engine (input tick, line, enable, nine, output char_valid, char_data, char_frame_error_flag, idle);
    modport ctrl (output tick, line, enable, nine, input char_valid, char_data, char_frame_error_flag, idle);
endinterface

// ===== src/asr_engine.sv
// Bit recovery engine: start detect, majority vote, shift
`timescale 1ns/1ps
module asr_engine
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    asr_rx_if.engine rx
);
    typedef struct packed {
        asr_state_e state;
        logic [3:0] phase;
        logic [3:0] bits;
        logic [8:0] shreg;
        logic samp_a;
        logic samp_b;
        logic line_q;
        logic char_valid;
        logic [8:0] char_data;
        logic char_frame_error_flag;
    } asr_eng_s;

    asr_eng_s r;
    asr_eng_s next_r;
    logic maj;

    // Two of three samples around centre [R23]
    assign maj = (r.samp_a & r.samp_b) | (r.samp_a & rx.line) | (r.samp_b & rx.line);

    // Next state of the engine
    always_comb begin
        next_r = r;
        next_r.line_q = rx.line;
        next_r.char_valid = 1'b0;
        if (!rx.enable) begin
            next_r.state = ASR_IDLE; // [R24] [R22]
        end else if (r.state == ASR_IDLE) begin
            if (r.line_q && !rx.line) begin
                next_r.state = ASR_START; // [R1]
                next_r.phase = 4'h0;
                next_r.bits = 4'h0;
            end
        end else if (rx.tick) begin
            next_r.phase = r.phase + 4'h1; // [R21]
            if (r.phase == PH_SAMPLE_A) begin
                next_r.samp_a = rx.line;
            end
            if (r.phase == PH_SAMPLE_B) begin
                next_r.samp_b = rx.line;
            end
            if (r.phase == PH_DECIDE) begin
                case (r.state)
                    ASR_START: begin
                        if (maj) begin
                            next_r.state = ASR_IDLE; // [R2]
                        end else begin
                            next_r.state = ASR_DATA;
                        end
                    end
                    ASR_DATA: begin
                        next_r.shreg = {maj, r.shreg[8:1]}; // [R3]
                        next_r.bits = r.bits + 4'h1;
                        if (r.bits == (rx.nine ? 4'h8 : 4'h7)) begin
                            next_r.state = ASR_STOP; // [R15]
                        end
                    end
                    ASR_STOP: begin
                        next_r.state = ASR_IDLE;
                        next_r.char_valid = 1'b1;
                        next_r.char_frame_error_flag = !maj; // [R4]
                        next_r.char_data = rx.nine ? r.shreg : {1'b0, r.shreg[8:1]};
                    end
                    default: begin
                        next_r.state = ASR_IDLE;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rx.char_valid = r.char_valid;
    assign rx.char_data = r.char_data;
    assign rx.char_frame_error_flag = r.char_frame_error_flag;
    assign rx.idle = (r.state == ASR_IDLE);
endmodule

// ===== src/asr_top.sv
// Serial receiver top: AXI4-Lite registers, baud tick, FIFO
`timescale 1ns/1ps
module asr_top
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic receive_line_pin,
    output logic receive_pin_claimed,
    output logic rx_irq
);
    typedef struct packed {
        // Bus channel state
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;

        // Software registers
        logic [7:0] rcv_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] baud_ctrl;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic [7:0] irq_en;
        logic [7:0] irq_ctrl;

        // Receive FIFO and status
        logic [1:0][9:0] fifo;
        logic rd_ptr;
        logic [1:0] count;
        logic overrun;

        // Baud tick and registered outputs
        logic [17:0] baud_cnt;
        logic tick;
        logic pending;
        logic irq;
        logic pin_claimed;
    } asr_top_s;

    asr_top_s r;
    asr_top_s next_r;
    asr_rx_if rx ();

    logic port_en;
    logic rx_active;
    logic head_ok;

    // ***************
    // Control decode
    // ***************
    assign port_en = r.rcv_ctrl[BIT_PORT_EN];
    assign rx_active = r.rcv_ctrl[BIT_CONT_EN] & !r.tx_ctrl[BIT_SYNC] & port_en; // [R20]
    assign head_ok = (r.count != 2'h0);

    // Engine hookup
    assign rx.tick = r.tick;
    assign rx.line = receive_line_pin;
    assign rx.enable = rx_active;
    assign rx.nine = r.rcv_ctrl[BIT_NINE];

    asr_engine asr_engine_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx(rx)
    );

    // Register read multiplexer
    function automatic logic [8:0] read_mux(input asr_top_s s, input logic [7:0] addr, input logic idle);
        logic [7:0] v;
        logic hit;
        v = 8'h00;
        hit = 1'b1;
        case (addr)
            OFS_RCV_STATUS: begin
                v = s.rcv_ctrl & MASK_RCV_STATUS;
                v[BIT_FRAME_ERROR_FLAG] = (s.count != 2'h0) & s.fifo[s.rd_ptr][9]; // [R9]
                v[BIT_OVERRUN_FLAG] = s.overrun;
                v[BIT_RECEIVED_NINTH_BIT] = (s.count != 2'h0) & s.fifo[s.rd_ptr][8]; // [R15]
            end

            OFS_RCV_DATA: begin
                v = s.fifo[s.rd_ptr][7:0];
            end

            OFS_BAUD_CTRL: begin
                v = s.baud_ctrl & MASK_BAUD_CTRL;
                v[BIT_IDLE] = idle;
            end

            OFS_DIV_LOW: begin
                v = s.div_low;
            end

            OFS_DIV_HIGH: begin
                v = s.div_high;
            end

            OFS_TX_STATUS: begin
                v = s.tx_ctrl & MASK_TX_STATUS;
                v[BIT_TX_EMPTY] = 1'b1;
            end

            OFS_IRQ_ENABLE: begin
                v = s.irq_en;
            end

            OFS_IRQ_FLAGS: begin
                v[BIT_RX_IRQ] = s.pending;
            end

            OFS_IRQ_CTRL: begin
                v = s.irq_ctrl & MASK_IRQ_CTRL;
            end

            default: begin
                hit = 1'b0;
            end
        endcase
        return {hit, v};
    endfunction

    // Main next-state logic
    always_comb begin
        logic [8:0] rd;
        logic do_write;
        logic pop;
        logic push;
        logic [17:0] period;
        logic wr_hit;
        rd = 9'h000;
        do_write = 1'b0;
        pop = 1'b0;
        push = 1'b0;
        period = 18'h00000;
        wr_hit = 1'b1;
        next_r = r;

        // Write channel capture, either order
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_have = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end

        if (s_axi_wvalid && r.wready) begin
            next_r.w_have = 1'b1;
            next_r.w_data = s_axi_wdata[7:0];
            next_r.w_lane = s_axi_wstrb[0];
        end

        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // Both halves held: do the write
        if (next_r.aw_have && next_r.w_have && !r.bvalid) begin
            do_write = 1'b1;
            next_r.aw_have = 1'b0;
            next_r.w_have = 1'b0;
            next_r.bvalid = 1'b1;
        end

        // Register writes, byte lane 0 only
        if (do_write) begin
            case (next_r.aw_addr)
                OFS_RCV_STATUS: begin
                    if (next_r.w_lane) begin
                        next_r.rcv_ctrl = next_r.w_data & MASK_RCV_STATUS;
                    end
                end

                OFS_BAUD_CTRL: begin
                    if (next_r.w_lane) begin
                        next_r.baud_ctrl = next_r.w_data & MASK_BAUD_CTRL;
                    end
                end

                OFS_DIV_LOW: begin
                    if (next_r.w_lane) begin
                        next_r.div_low = next_r.w_data;
                        next_r.baud_cnt = 18'h00000;
                    end
                end

                OFS_DIV_HIGH: begin
                    if (next_r.w_lane) begin
                        next_r.div_high = next_r.w_data;
                        next_r.baud_cnt = 18'h00000;
                    end
                end

                OFS_TX_STATUS: begin
                    if (next_r.w_lane) begin
                        next_r.tx_ctrl = next_r.w_data & MASK_TX_STATUS;
                    end
                end

                OFS_IRQ_ENABLE: begin
                    if (next_r.w_lane) begin
                        next_r.irq_en = next_r.w_data;
                    end
                end

                OFS_IRQ_CTRL: begin
                    if (next_r.w_lane) begin
                        next_r.irq_ctrl = next_r.w_data & MASK_IRQ_CTRL;
                    end
                end

                OFS_RCV_DATA, OFS_IRQ_FLAGS: begin
                    wr_hit = 1'b1; // Read-only, write ignored [R7]
                end

                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            next_r.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Read channel
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // Address taken: answer next cycle
        if (s_axi_arvalid && r.arready) begin
            rd = read_mux(r, s_axi_araddr, rx.idle);
            next_r.rvalid = 1'b1;
            next_r.rdata = rd[7:0];
            next_r.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
            pop = (s_axi_araddr == OFS_RCV_DATA) && head_ok; // [R6] [R10]
        end

        next_r.awready = !next_r.aw_have && !next_r.bvalid;
        next_r.wready = !next_r.w_have && !next_r.bvalid;
        next_r.arready = !next_r.rvalid;

        // Baud tick at sixteen per bit
        period = r.baud_ctrl[BIT_WIDE_DIV] ? {2'b00, r.div_high, r.div_low} : {10'h000, r.div_low};
        if (!r.tx_ctrl[BIT_HIGH_RATE]) begin
            period = ((period + 18'h00001) << LOW_RATE_SHIFT) - 18'h00001;
        end

        next_r.tick = 1'b0;
        if (!rx_active) begin
            next_r.baud_cnt = 18'h00000;
        end else if (r.baud_cnt >= period) begin
            next_r.baud_cnt = 18'h00000;
            next_r.tick = 1'b1; // [R21]
        end else if (next_r.baud_cnt == r.baud_cnt) begin
            next_r.baud_cnt = r.baud_cnt + 18'h00001;
        end

        // Character arrival into the FIFO
        if (rx.char_valid && rx_active && !r.overrun) begin // [R14] [R12]
            if (r.rcv_ctrl[BIT_NINE] && r.rcv_ctrl[BIT_ADDR_EN] && !rx.char_data[8]) begin
                push = 1'b0; // [R17]
            end else if (r.count == FIFO_DEPTH && !pop) begin
                next_r.overrun = 1'b1; // [R13]
            end else begin
                push = 1'b1; // [R5]
            end
        end

        if (push) begin
            next_r.fifo[r.rd_ptr ^ r.count[0]] = {rx.char_frame_error_flag, rx.char_data}; // [R9]
        end

        if (pop) begin
            next_r.rd_ptr = !r.rd_ptr; // [R6]
        end

        next_r.count = r.count + {1'b0, push} - {1'b0, pop};

        // Receive disable clears overrun only [R14] [R11]
        if (!r.rcv_ctrl[BIT_CONT_EN]) begin
            next_r.overrun = 1'b0;
        end
        // Port disable resets the receive path [R22] [R11]
        if (!port_en) begin
            next_r.overrun = 1'b0;
            next_r.count = 2'h0;
            next_r.rd_ptr = 1'b0;
            next_r.fifo = '0;
        end

        // Pending flag and gated interrupt
        next_r.pending = rx_active && (next_r.count != 2'h0); // [R7]
        next_r.irq = next_r.pending && next_r.irq_en[BIT_RX_IRQ] && next_r.irq_ctrl[BIT_PERIPH_EN]
            && next_r.irq_ctrl[BIT_GLOBAL_EN]; // [R8]
        next_r.pin_claimed = next_r.rcv_ctrl[BIT_PORT_EN]; // [R22]
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ***************
    // Outputs
    // ***************
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = {24'h000000, r.rdata};
    assign receive_pin_claimed = r.pin_claimed;
    assign rx_irq = r.irq;
endmodule

// ===== tb/asr_asserts.sv
// Checker of bus and pin behaviour at the receiver top
`timescale 1ns/1ps
module asr_asserts
    import asr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic receive_pin_claimed,
    input wire logic rx_irq
);
    // ****
    // Handshake steps
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ****
    // Properties
    // ****
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid && !s_axi_awready)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_unmapped_err: assert property (s_rd_take and s_axi_araddr > OFS_IRQ_CTRL |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_claim_follows: assert property (s_wr_take and s_axi_awaddr == OFS_RCV_STATUS |->
        ##2 receive_pin_claimed == $past(s_axi_wdata[BIT_PORT_EN], 2)) else $error("pin claim wrong");
    a_irq_masked: assert property (s_wr_take and s_axi_awaddr == OFS_IRQ_CTRL &&
        !s_axi_wdata[BIT_GLOBAL_EN] |-> ##2 !rx_irq [*2]) else $error("irq while masked");
endmodule
bind asr_top asr_asserts asr_asserts_inst (.*);

// ===== tb/asr_remote_tx.sv
// Remote serial transmitter model on the receive line
`timescale 1ns/1ps
module asr_remote_tx #(
    parameter int BIT_CLKS = 32
) (
    input wire logic aclk,
    output logic line
);
    // Idle high between frames
    initial begin
        line = 1'b1;
    end
    // ****
    // Frame sender, lsb first
    // ****
    task automatic send(input logic [8:0] d, input int n, input logic stop);
        line <= 1'b0; // Start bit
        repeat (BIT_CLKS) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            line <= d[i]; // Data bit
            repeat (BIT_CLKS) @(posedge aclk);
        end
        line <= stop; // Stop level
        repeat (BIT_CLKS) @(posedge aclk);
        line <= 1'b1;
        repeat (BIT_CLKS) @(posedge aclk);
    endtask
    // Short low pulse shorter than half a bit
    task automatic glitch(input int clks);
        line <= 1'b0; // False start
        repeat (clks) @(posedge aclk);
        line <= 1'b1;
        repeat (BIT_CLKS) @(posedge aclk);
    endtask
endmodule

// ===== tb/tb_asr_top.sv
// Self-checking bench for the serial receiver top
`timescale 1ns/1ps
module tb_asr_top
    import asr_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, claimed, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    wire line;
    int n_errors = 0;
    int cmp_count = 0;
    // Clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    asr_top asr_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .receive_line_pin(line), .receive_pin_claimed(claimed), .rx_irq(irq));
    asr_remote_tx #(.BIT_CLKS(32)) asr_remote_tx_inst (.aclk(aclk), .line(line));
    // ****
    // Bus and compare tasks
    // ****
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end while (!(aw_ok && w_ok));
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({r, d[29:0]}, {RESP_OKAY, 22'h0, e});
    endtask
    task automatic ck_irq(input logic e);
        repeat (2) @(posedge aclk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rc(OFS_RCV_STATUS, 8'h00);
        rc(OFS_TX_STATUS, 8'h02);
        rc(OFS_IRQ_FLAGS, 8'h00);
        rd(8'h24, d, r);
        chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
        wr(OFS_DIV_LOW, 8'h01);
        wr(OFS_TX_STATUS, 8'h04);
        wr(OFS_IRQ_ENABLE, 8'h20);
        wr(OFS_IRQ_CTRL, 8'hc0);
        wr(OFS_RCV_STATUS, 8'h90); // Receive enable last
        rc(OFS_RCV_STATUS, 8'h90); // Active setting
        $display("done regs");
    endtask
    task automatic t_basic();
        asr_remote_tx_inst.send(9'h0a5, 8, 1'b1);
        rc(OFS_IRQ_FLAGS, 8'h20); // Pending set
        ck_irq(1'b1); // All enables on
        wr(OFS_IRQ_FLAGS, 8'h00);
        rc(OFS_IRQ_FLAGS, 8'h20); // Not clearable
        wr(OFS_IRQ_CTRL, 8'h40);
        ck_irq(1'b0); // Global off
        rc(OFS_IRQ_FLAGS, 8'h20); // Flag ignores enables
        wr(OFS_IRQ_CTRL, 8'hc0);
        rc(OFS_RCV_DATA, 8'ha5); // Oldest byte
        rc(OFS_IRQ_FLAGS, 8'h00); // Popped
        ck_irq(1'b0); // Nothing pending
        $display("done basic");
    endtask
    task automatic t_frame_error_flag();
        asr_remote_tx_inst.send(9'h03c, 8, 1'b0);
        asr_remote_tx_inst.send(9'h05a, 8, 1'b1);
        rc(OFS_RCV_STATUS, 8'h94); // Oldest errored
        rc(OFS_RCV_DATA, 8'h3c); // Still received
        rc(OFS_RCV_STATUS, 8'h90); // Advanced
        rc(OFS_RCV_DATA, 8'h5a); // Next byte
        asr_remote_tx_inst.send(9'h0c3, 8, 1'b0);
        asr_remote_tx_inst.send(9'h081, 8, 1'b0);
        rc(OFS_RCV_DATA, 8'hc3);
        rc(OFS_RCV_STATUS, 8'h94); // Stays set
        rc(OFS_RCV_DATA, 8'h81);
        $display("done frame_error_flag");
    endtask
    task automatic t_glitch();
        asr_remote_tx_inst.glitch(10);
        rc(OFS_IRQ_FLAGS, 8'h00); // Abandoned
        rc(OFS_RCV_STATUS, 8'h90); // No error
        wr(OFS_TX_STATUS, 8'h14); // Sync set: receiver off
        asr_remote_tx_inst.send(9'h066, 8, 1'b1);
        rc(OFS_IRQ_FLAGS, 8'h00); // Nothing taken
        wr(OFS_TX_STATUS, 8'h04);
        $display("done glitch");
    endtask
    task automatic t_over();
        asr_remote_tx_inst.send(9'h011, 8, 1'b1);
        asr_remote_tx_inst.send(9'h022, 8, 1'b1);
        rc(OFS_RCV_STATUS, 8'h90); // Two fit
        asr_remote_tx_inst.send(9'h033, 8, 1'b1);
        rc(OFS_RCV_STATUS, 8'h92); // Third overruns
        rc(OFS_RCV_DATA, 8'h11); // Kept readable
        asr_remote_tx_inst.send(9'h044, 8, 1'b1);
        rc(OFS_RCV_DATA, 8'h22); // Kept readable
        rc(OFS_IRQ_FLAGS, 8'h00); // Refused while overrun
        wr(OFS_RCV_STATUS, 8'h80);
        rc(OFS_RCV_STATUS, 8'h80); // Cleared by disable
        wr(OFS_RCV_STATUS, 8'h90);
        $display("done over");
    endtask
    task automatic t_enable();
        asr_remote_tx_inst.send(9'h0f0, 8, 1'b0);
        wr(OFS_RCV_STATUS, 8'h80);
        rc(OFS_RCV_STATUS, 8'h84); // Error kept
        wr(OFS_RCV_STATUS, 8'h00);
        chk({31'h0, claimed}, 32'h0); // Pins released
        wr(OFS_RCV_STATUS, 8'h90);
        rc(OFS_RCV_STATUS, 8'h90); // Error forced off
        fork
            asr_remote_tx_inst.send(9'h0ff, 8, 1'b1);
            begin
                repeat (100) @(posedge aclk);
                wr(OFS_RCV_STATUS, 8'h80);
                wr(OFS_RCV_STATUS, 8'h90);
            end
        join
        rc(OFS_IRQ_FLAGS, 8'h00); // Aborted frame
        $display("done enable");
    endtask
    task automatic t_nine();
        wr(OFS_RCV_STATUS, 8'hd0);
        asr_remote_tx_inst.send(9'h1a5, 9, 1'b1);
        rc(OFS_RCV_STATUS, 8'hd1); // Ninth bit first
        rc(OFS_RCV_DATA, 8'ha5); // Low byte
        wr(OFS_RCV_STATUS, 8'hd8);
        asr_remote_tx_inst.send(9'h012, 9, 1'b1);
        asr_remote_tx_inst.send(9'h155, 9, 1'b1);
        rc(OFS_RCV_STATUS, 8'hd9); // Address kept
        rc(OFS_RCV_DATA, 8'h55); // Data dropped
        rc(OFS_IRQ_FLAGS, 8'h00); // Only one entry
        wr(OFS_RCV_STATUS, 8'hd0); // Leave address mode
        asr_remote_tx_inst.send(9'h034, 9, 1'b1);
        rc(OFS_RCV_STATUS, 8'hd0);
        rc(OFS_RCV_DATA, 8'h34); // Data accepted
        $display("done nine");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_basic();
        t_frame_error_flag();
        t_glitch();
        t_over();
        t_enable();
        t_nine();
        end_sim();
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        end_sim();
    end
endmodule
